/* File: rtl/dpa_pkg.sv */
// shared constants and types for the debug port acquire block
package dpa_pkg;

    // core clock and window timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int WIN_SHORT_US = 8;
    localparam int WIN_LONG_US = 400;
    // both window times round down to whole cycles
    localparam int WIN_SHORT_CYC = (WIN_SHORT_US * 1000000) / CLK_PERIOD_PS;
    localparam int WIN_LONG_CYC = (WIN_LONG_US * 1000000) / CLK_PERIOD_PS;
    localparam int TIMER_W = 17;

    // debug clock edges that stretch the window
    localparam int EDGE_CNT_W = 4;
    localparam logic [EDGE_CNT_W-1:0] EDGES_TO_EXTEND = 4'h8;

    // acquire key, arbitrary neutral value
    localparam int KEY_W = 32;
    localparam logic [KEY_W-1:0] ACQ_KEY_DEFAULT = 32'h5a3c_96e1;

    // synchroniser lanes into the core domain
    localparam int SYNC_W = 5;
    localparam int LN_P1_EIGHT = 0;
    localparam int LN_P1_KEY = 1;
    localparam int LN_USB_EIGHT = 2;
    localparam int LN_USB_KEY = 3;
    localparam int LN_LOCKOUT = 4;

    // settle cycles before the lockout level is trusted
    localparam logic [1:0] SETTLE_CYC = 2'h3;

    // avalon register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

    // control register fields
    localparam int CTRL_FW_DBG_EN = 0;

    // status register fields
    localparam int ST_STATE_LSB = 0;
    localparam int ST_STATE_MSB = 2;
    localparam int ST_P1_ACT = 4;
    localparam int ST_USB_ACT = 5;
    localparam int ST_LOCKED_BIT = 6;
    localparam int ST_EXTENDED = 7;
    localparam int ST_TRACE = 8;
    localparam int ST_DBG_MOD = 9;

    // acquire sequence states
    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_SHORT,
        ST_LONG,
        ST_ACQ,
        ST_EXPIRED,
        ST_LOCKED
    } dpa_state_t;

endpackage : dpa_pkg

/* File: rtl/dpa_sync2.sv */
// two-flop level synchroniser into the core clock domain
`timescale 1ns/1ns
module dpa_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end

endmodule : dpa_sync2

/* File: rtl/dpa_key_rx.sv */
// key receiver and edge counter on one debug pin pair's own clock
`timescale 1ns/1ns
module dpa_key_rx #(
    parameter logic [dpa_pkg::KEY_W-1:0] ACQ_KEY = dpa_pkg::ACQ_KEY_DEFAULT
) (
    input wire logic i_link_clk,
    input wire logic i_rst_b,
    input wire logic i_data,
    output logic o_eight_seen,
    output logic o_key_seen
);

    logic [dpa_pkg::EDGE_CNT_W-1:0] edge_cnt;
    logic [dpa_pkg::KEY_W-1:0] shift;

    // count rising clock edges, saturating at the extend threshold
    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            edge_cnt <= '0;
            o_eight_seen <= 1'b0;
        end else if (edge_cnt != dpa_pkg::EDGES_TO_EXTEND) begin
            edge_cnt <= edge_cnt + 1'b1;
            // flag rises on the eighth edge itself
            o_eight_seen <= (edge_cnt + 1'b1) == dpa_pkg::EDGES_TO_EXTEND;
        end
    end

    // shift data in msb first; match is sticky because the clock may stop
    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift <= '0;
            o_key_seen <= 1'b0;
        end else begin
            shift <= {shift[dpa_pkg::KEY_W-2:0], i_data};
            if ({shift[dpa_pkg::KEY_W-2:0], i_data} == ACQ_KEY) begin
                o_key_seen <= 1'b1;
            end
        end
    end

endmodule : dpa_key_rx

/* File: rtl/dpa_acquire.sv */
// debug port acquisition window, pin pair select and access gating
//
// Functional notes
// - no programming or debug access before acquisition
// - eight microsecond acquire window after every reset
// - eight debug clock edges extend window 400us
// - two wires: host clock plus bidirectional data; this block only takes each data pin as an input
// - debug enabled on at most one pair
// - usb pair active withholds port1 clock gpio
// - trace output follows serial debug activation
// - debug modules off after reset, firmware enables
// - debug left off recoverable only by erase
// - lockout disables every external access interface
// - lockout latch sampled only at reset
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
module dpa_acquire #(
    parameter int WIN_LONG_CYC = dpa_pkg::WIN_LONG_CYC,
    parameter logic [dpa_pkg::KEY_W-1:0] ACQ_KEY = dpa_pkg::ACQ_KEY_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    // port-1 debug pair
    input wire logic i_port1_debug_clock_pin,
    input wire logic i_port1_debug_data,
    // usb data pins used as debug pair
    input wire logic i_usb_debug_clock_pin,
    input wire logic i_usb_debug_data,
    // nonvolatile lockout level
    input wire logic i_one_time_lockout_latch,
    // avalon-mm slave
    input wire logic [dpa_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // gating towards pins and debug logic
    output logic o_access_grant,
    output logic o_port1_debug_en,
    output logic o_usb_debug_en,
    output logic o_port1_clk_gpio_block,
    output logic o_serial_trace_output_en,
    output logic o_debug_modules_en,
    output logic o_lockout_active
);

    dpa_pkg::dpa_state_t state;
    dpa_pkg::dpa_state_t next_state;

    logic [dpa_pkg::SYNC_W-1:0] async_lanes;
    logic [dpa_pkg::SYNC_W-1:0] sync_lanes;
    logic p1_eight_raw;
    logic p1_key_raw;
    logic usb_eight_raw;
    logic usb_key_raw;
    logic p1_eight;
    logic p1_key;
    logic usb_eight;
    logic usb_key;
    logic lockout_sync;

    logic [1:0] settle_cnt;
    logic [dpa_pkg::TIMER_W-1:0] win_timer;
    logic lockout;
    logic extended;
    logic sel_usb;
    logic fw_dbg_en;
    logic bus_go;
    logic bus_wr;

    // status code for software, kept in one place
    function automatic logic [2:0] state_code(input dpa_pkg::dpa_state_t s);
        state_code = 3'(s);
    endfunction : state_code

    // true when the window timer has reached a given length
    function automatic logic timer_done(
        input logic [dpa_pkg::TIMER_W-1:0] t,
        input int lim
    );
        timer_done = t >= dpa_pkg::TIMER_W'(lim - 1);
    endfunction : timer_done

    // settle is over once the counter reaches its last step
    function automatic logic settle_done(input logic [1:0] c);
        settle_done = c == dpa_pkg::SETTLE_CYC;
    endfunction : settle_done

    // a key seen on either pair claims the port
    function automatic logic key_on_any(input logic p1, input logic usb);
        key_on_any = p1 || usb;
    endfunction : key_on_any

    // acquired is the only state that opens the pins
    function automatic logic acquired(input dpa_pkg::dpa_state_t s);
        acquired = s == dpa_pkg::ST_ACQ;
    endfunction : acquired

    // one receiver per pair so either pair can carry the key
    dpa_key_rx #(
        .ACQ_KEY(ACQ_KEY)
    ) u_rx_port1 (
        .i_link_clk(i_port1_debug_clock_pin),
        .i_rst_b(i_rst_b),
        .i_data(i_port1_debug_data),
        .o_eight_seen(p1_eight_raw),
        .o_key_seen(p1_key_raw)
    );

    dpa_key_rx #(
        .ACQ_KEY(ACQ_KEY)
    ) u_rx_usb (
        .i_link_clk(i_usb_debug_clock_pin),
        .i_rst_b(i_rst_b),
        .i_data(i_usb_debug_data),
        .o_eight_seen(usb_eight_raw),
        .o_key_seen(usb_key_raw)
    );

    // every lane is a sticky level, so two flops are a sound crossing
    always_comb begin
        async_lanes = '0;
        async_lanes[dpa_pkg::LN_P1_EIGHT] = p1_eight_raw;
        async_lanes[dpa_pkg::LN_P1_KEY] = p1_key_raw;
        async_lanes[dpa_pkg::LN_USB_EIGHT] = usb_eight_raw;
        async_lanes[dpa_pkg::LN_USB_KEY] = usb_key_raw;
        async_lanes[dpa_pkg::LN_LOCKOUT] = i_one_time_lockout_latch;
    end

    dpa_sync2 #(
        .W(dpa_pkg::SYNC_W)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async(async_lanes),
        .o_sync(sync_lanes)
    );

    assign p1_eight = sync_lanes[dpa_pkg::LN_P1_EIGHT];
    assign p1_key = sync_lanes[dpa_pkg::LN_P1_KEY];
    assign usb_eight = sync_lanes[dpa_pkg::LN_USB_EIGHT];
    assign usb_key = sync_lanes[dpa_pkg::LN_USB_KEY];
    assign lockout_sync = sync_lanes[dpa_pkg::LN_LOCKOUT];

    // wait for the synchroniser to fill before trusting the lockout level
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            settle_cnt <= '0;
        end else if (state == dpa_pkg::ST_SETTLE) begin
            settle_cnt <= settle_cnt + 1'b1;
        end
    end

    // lockout is caught once after reset and then frozen
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lockout <= 1'b0;
        end else if (state == dpa_pkg::ST_SETTLE &&
                     settle_done(settle_cnt)) begin
            lockout <= lockout_sync;
        end
    end

    // window timer runs from the end of settle; the long window keeps the same origin
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            win_timer <= '0;
        end else if (state == dpa_pkg::ST_SHORT ||
                     state == dpa_pkg::ST_LONG) begin
            win_timer <= win_timer + 1'b1;
        end
    end

    // acquire sequence
    always_comb begin
        next_state = state;
        case (state)
            dpa_pkg::ST_SETTLE: begin
                if (settle_done(settle_cnt)) begin
                    if (lockout_sync) begin
                        next_state = dpa_pkg::ST_LOCKED;
                    end else begin
                        next_state = dpa_pkg::ST_SHORT;
                    end
                end
            end
            dpa_pkg::ST_SHORT: begin
                if (key_on_any(p1_key, usb_key)) begin
                    next_state = dpa_pkg::ST_ACQ;
                end else if (p1_eight || usb_eight) begin
                    next_state = dpa_pkg::ST_LONG;
                end else if (timer_done(win_timer,
                                        dpa_pkg::WIN_SHORT_CYC)) begin
                    next_state = dpa_pkg::ST_EXPIRED;
                end
            end
            dpa_pkg::ST_LONG: begin
                if (key_on_any(p1_key, usb_key)) begin
                    next_state = dpa_pkg::ST_ACQ;
                end else if (timer_done(win_timer, WIN_LONG_CYC)) begin
                    next_state = dpa_pkg::ST_EXPIRED;
                end
            end
            // acquired, expired and locked hold until the next reset
            dpa_pkg::ST_ACQ: next_state = dpa_pkg::ST_ACQ;
            dpa_pkg::ST_EXPIRED: next_state = dpa_pkg::ST_EXPIRED;
            dpa_pkg::ST_LOCKED: next_state = dpa_pkg::ST_LOCKED;
            default: next_state = dpa_pkg::ST_SETTLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= dpa_pkg::ST_SETTLE;
        end else begin
            state <= next_state;
        end
    end

    // remember that the window was stretched, for software visibility
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            extended <= 1'b0;
        end else if (state == dpa_pkg::ST_SHORT &&
                     next_state == dpa_pkg::ST_LONG) begin
            extended <= 1'b1;
        end
    end

    // pair choice is made once, on entry to acquired; port1 wins a tie
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel_usb <= 1'b0;
        end else if (state != dpa_pkg::ST_ACQ &&
                     next_state == dpa_pkg::ST_ACQ) begin
            sel_usb <= !p1_key;
        end
    end

    // grant opens access; acquired is never reached under lockout
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_access_grant <= 1'b0;
        end else begin
            o_access_grant <= acquired(state);
        end
    end

    // only the pair that carried the key is switched to debug
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_port1_debug_en <= 1'b0;
            o_usb_debug_en <= 1'b0;
        end else begin
            o_port1_debug_en <= acquired(state) && !sel_usb;
            o_usb_debug_en <= acquired(state) && sel_usb;
        end
    end

    // keep the port1 clock pin off gpio while usb carries debug
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_port1_clk_gpio_block <= 1'b0;
        end else begin
            o_port1_clk_gpio_block <= acquired(state) && sel_usb;
        end
    end

    // trace has no enable of its own; it rides on the debug port
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_serial_trace_output_en <= 1'b0;
        end else begin
            o_serial_trace_output_en <= acquired(state);
        end
    end

    // debug modules need firmware consent and no lockout
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_debug_modules_en <= 1'b0;
        end else begin
            o_debug_modules_en <= fw_dbg_en && !lockout &&
                                  state != dpa_pkg::ST_SETTLE;
        end
    end

    // lockout shown outside is the value caught after reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_lockout_active <= 1'b0;
        end else begin
            o_lockout_active <= lockout;
        end
    end

    // avalon handshake: one wait cycle, then the answer with waitrequest low
    assign bus_go = (i_avs_read || i_avs_write) && o_avs_waitrequest;
    assign bus_wr = i_avs_write && !o_avs_waitrequest;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !bus_go;
        end
    end

    // firmware is the only writer of the module enable; reset clears it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fw_dbg_en <= 1'b0;
        end else if (bus_wr && i_avs_address == dpa_pkg::REG_CTRL) begin
            fw_dbg_en <= i_avs_writedata[dpa_pkg::CTRL_FW_DBG_EN];
        end
    end

    // read data is loaded with the answer and held until the next one
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_readdata <= '0;
        end else if (bus_go && i_avs_read) begin
            o_avs_readdata <= '0;
            case (i_avs_address)
                dpa_pkg::REG_CTRL: begin
                    o_avs_readdata[dpa_pkg::CTRL_FW_DBG_EN] <= fw_dbg_en;
                end
                dpa_pkg::REG_STATUS: begin
                    o_avs_readdata[dpa_pkg::ST_STATE_MSB:
                                   dpa_pkg::ST_STATE_LSB] <= state_code(state);
                    o_avs_readdata[dpa_pkg::ST_P1_ACT] <= o_port1_debug_en;
                    o_avs_readdata[dpa_pkg::ST_USB_ACT] <= o_usb_debug_en;
                    o_avs_readdata[dpa_pkg::ST_LOCKED_BIT] <= lockout;
                    o_avs_readdata[dpa_pkg::ST_EXTENDED] <= extended;
                    o_avs_readdata[dpa_pkg::ST_TRACE] <=
                        o_serial_trace_output_en;
                    o_avs_readdata[dpa_pkg::ST_DBG_MOD] <= o_debug_modules_en;
                end
                // unmapped addresses read as zero
                default: o_avs_readdata <= '0;
            endcase
        end
    end

endmodule : dpa_acquire

/* File: test/dpa_acquire_props.sv */
// concurrent checks on the acquire block's outputs
`timescale 1ns/1ns
module dpa_acquire_props #(
    parameter int WIN_LONG_CYC = 3000
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic o_access_grant,
    input wire logic o_port1_debug_en,
    input wire logic o_usb_debug_en,
    input wire logic o_port1_clk_gpio_block,
    input wire logic o_serial_trace_output_en,
    input wire logic o_debug_modules_en,
    input wire logic o_lockout_active
);
    logic [31:0] cyc;
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // cycles since reset release; saturates so a long run never wraps
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cyc <= 32'h0;
        end else if (cyc != 32'hffff_ffff) begin
            cyc <= cyc + 32'h1;
        end
    end
    property p_one_pair;
        !(o_port1_debug_en && o_usb_debug_en);
    endproperty
    a_one_pair: assert property (p_one_pair)
        else $error("both debug pairs enabled");
    property p_gpio_block;
        o_port1_clk_gpio_block == o_usb_debug_en;
    endproperty
    a_gpio_block: assert property (p_gpio_block)
        else $error("port1 clock pin block differs from usb debug");
    property p_trace;
        o_serial_trace_output_en == o_access_grant;
    endproperty
    a_trace: assert property (p_trace)
        else $error("trace enable differs from grant");
    property p_lock_gate;
        o_lockout_active |-> !o_access_grant && !o_debug_modules_en;
    endproperty
    a_lock_gate: assert property (p_lock_gate)
        else $error("access open under lockout");
    property p_lock_hold;
        o_lockout_active |=> o_lockout_active;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lockout dropped without reset");
    property p_grant_pair;
        o_access_grant |-> o_port1_debug_en || o_usb_debug_en;
    endproperty
    a_grant_pair: assert property (p_grant_pair)
        else $error("grant without a debug pair");
    property p_grant_hold;
        o_access_grant |=> o_access_grant && $stable(o_usb_debug_en);
    endproperty
    a_grant_hold: assert property (p_grant_hold)
        else $error("grant or pair changed before reset");
    property p_grant_time;
        $rose(o_access_grant) |-> cyc > 40 && cyc < WIN_LONG_CYC + 16;
    endproperty
    a_grant_time: assert property (p_grant_time)
        else $error("grant outside the acquire window");
    property p_modules_reset;
        $rose(i_rst_b) |-> !o_debug_modules_en [*4];
    endproperty
    a_modules_reset: assert property (p_modules_reset)
        else $error("debug modules on right after reset");
    property p_bus_answer;
        (i_avs_read || i_avs_write) && o_avs_waitrequest
            |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not a one cycle pulse");
endmodule : dpa_acquire_props

/* File: test/dpa_host_model.sv */
// host debugger model driving the two debug pin pairs
`timescale 1ns/1ns
module dpa_host_model #(
    parameter int HALF_NS = 24
) (
    output logic o_p1_clk,
    output logic o_p1_data,
    output logic o_usb_clk,
    output logic o_usb_data
);
    logic clk = 1'b0;
    logic dat = 1'b0;
    logic sel = 1'b0;
    // only the chosen pair sees the host clock; it rests low between frames
    assign o_p1_clk = clk & ~sel;
    assign o_usb_clk = clk & sel;
    // the idle pair shows the inverse so no stale value looks valid
    assign o_p1_data = sel ? ~dat : dat;
    assign o_usb_data = sel ? dat : ~dat;
    // one data bit per rising host clock, data set half a period ahead
    task automatic bit_out(input logic b);
        dat = b;
        #(HALF_NS) clk = 1'b1;
        #(HALF_NS) clk = 1'b0;
    endtask : bit_out
    // plain clock edges, as a host does before the key
    task automatic clocks(input logic usb, input int n);
        sel = usb;
        #3;
        for (int i = 0; i < n; i++) begin
            bit_out(i[0]);
        end
        dat = ~dat;
    endtask : clocks
    // acquire key, msb first, on the chosen pair
    task automatic send(input logic usb, input logic [31:0] key);
        sel = usb;
        #3;
        for (int i = 31; i >= 0; i--) begin
            bit_out(key[i]);
        end
        dat = ~dat;
    endtask : send
endmodule : dpa_host_model

/* File: test/dpa_acquire_bench.sv */
// self-checking bench for the debug port acquire block
`timescale 1ns/1ns
module dpa_acquire_bench;
    localparam int WLONG = 3000;
    localparam logic [31:0] KEY = dpa_pkg::ACQ_KEY_DEFAULT;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic lock = 1'b0;
    logic [dpa_pkg::ADDR_W-1:0] adr = 4'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] got;
    logic wreq, grant, p1_en, usb_en, gpio_blk, trace_en, mod_en, lock_act;
    logic p1_clk, p1_dat, usb_clk, usb_dat;
    int n_mismatch = 0;
    int comparisons = 0;
    // core clock, 4 ns period
    always #2 i_clk = ~i_clk;
    dpa_host_model u_host (.o_p1_clk(p1_clk), .o_p1_data(p1_dat),
        .o_usb_clk(usb_clk), .o_usb_data(usb_dat));
    dpa_acquire #(.WIN_LONG_CYC(WLONG)) u_dut (.i_clk(i_clk),
        .i_rst_b(i_rst_b), .i_port1_debug_clock_pin(p1_clk),
        .i_port1_debug_data(p1_dat), .i_usb_debug_clock_pin(usb_clk),
        .i_usb_debug_data(usb_dat), .i_one_time_lockout_latch(lock),
        .i_avs_address(adr), .i_avs_read(rd_en), .i_avs_write(wr_en),
        .i_avs_writedata(wdat), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .o_access_grant(grant),
        .o_port1_debug_en(p1_en), .o_usb_debug_en(usb_en),
        .o_port1_clk_gpio_block(gpio_blk),
        .o_serial_trace_output_en(trace_en),
        .o_debug_modules_en(mod_en), .o_lockout_active(lock_act));
    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge i_clk);
        adr <= a;
        wdat <= wd;
        wr_en <= wr;
        rd_en <= ~wr;
        do begin
            @(posedge i_clk);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        if (n >= 100) n_mismatch++;
        rd = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask : bus
    // reset with a chosen lockout level, then let the settle run out
    task automatic reset_dut(input logic lk);
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        lock <= lk;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (6) @(posedge i_clk);
    endtask : reset_dut
    task automatic test_done();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // register access, then port1 acquire late in the extended window
    initial begin
        reset_dut(1'b0);
        bus(1'b0, dpa_pkg::REG_STATUS, 32'h0, got);
        chk("status short", got, 32'h1);
        bus(1'b0, dpa_pkg::REG_CTRL, 32'h0, got);
        chk("ctrl reset", got, 32'h0);
        chk("modules off", mod_en, 32'h0);
        bus(1'b1, 4'hc, 32'hffff_ffff, got);
        bus(1'b0, 4'hc, 32'h0, got);
        chk("unmapped", got, 32'h0);
        chk("unmapped no enable", mod_en, 32'h0);
        bus(1'b1, dpa_pkg::REG_CTRL, 32'h1, got);
        bus(1'b0, dpa_pkg::REG_CTRL, 32'h0, got);
        chk("ctrl rw", got, 32'h1);
        u_host.clocks(1'b0, 8);
        repeat (10) @(posedge i_clk);
        bus(1'b0, dpa_pkg::REG_STATUS, 32'h0, got);
        chk("status long", got, 32'h282);
        repeat (2200) @(posedge i_clk);
        u_host.send(1'b0, KEY);
        repeat (10) @(posedge i_clk);
        chk("p1 grant", {grant, p1_en, usb_en, gpio_blk, trace_en, mod_en},
            32'h33);
        bus(1'b0, dpa_pkg::REG_STATUS, 32'h0, got);
        chk("status acq", got & 32'h37f, 32'h313);
        u_host.send(1'b1, KEY);
        repeat (10) @(posedge i_clk);
        chk("one pair", {p1_en, usb_en}, 32'h2);
        bus(1'b1, dpa_pkg::REG_CTRL, 32'h0, got);
        repeat (2) @(posedge i_clk);
        chk("modules off again", mod_en, 32'h0);
        // usb pair acquire inside the short window, firmware silent
        reset_dut(1'b0);
        u_host.send(1'b1, KEY);
        repeat (10) @(posedge i_clk);
        chk("usb grant", {grant, p1_en, usb_en, gpio_blk, trace_en, mod_en},
            32'h2e);
        // short window runs out with no host activity
        reset_dut(1'b0);
        repeat (2100) @(posedge i_clk);
        bus(1'b0, dpa_pkg::REG_STATUS, 32'h0, got);
        chk("short expired", got & 32'h7, 32'h4);
        u_host.send(1'b0, KEY);
        repeat (10) @(posedge i_clk);
        chk("late key", {grant, p1_en, trace_en}, 32'h0);
        // long window runs out after the eight edges
        reset_dut(1'b0);
        u_host.clocks(1'b0, 8);
        repeat (WLONG + 100) @(posedge i_clk);
        bus(1'b0, dpa_pkg::REG_STATUS, 32'h0, got);
        chk("long expired", got & 32'h7, 32'h4);
        u_host.send(1'b1, KEY);
        repeat (10) @(posedge i_clk);
        chk("late usb key", {grant, usb_en, gpio_blk}, 32'h0);
        // lockout caught at reset shuts every path
        reset_dut(1'b1);
        bus(1'b0, dpa_pkg::REG_STATUS, 32'h0, got);
        chk("status locked", got, 32'h45);
        bus(1'b1, dpa_pkg::REG_CTRL, 32'h1, got);
        u_host.send(1'b0, KEY);
        repeat (10) @(posedge i_clk);
        chk("locked outs", {grant, p1_en, usb_en, trace_en, mod_en, lock_act},
            32'h1);
        lock <= 1'b0;
        repeat (20) @(posedge i_clk);
        chk("lock kept", lock_act, 32'h1);
        reset_dut(1'b0);
        chk("lock cleared", lock_act, 32'h0);
        test_done();
    end
    // watchdog sized well past the roughly 10k cycle run
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end
endmodule : dpa_acquire_bench
bind dpa_acquire dpa_acquire_props #(.WIN_LONG_CYC(WIN_LONG_CYC)) u_props (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .o_access_grant(o_access_grant), .o_port1_debug_en(o_port1_debug_en),
    .o_usb_debug_en(o_usb_debug_en),
    .o_port1_clk_gpio_block(o_port1_clk_gpio_block),
    .o_serial_trace_output_en(o_serial_trace_output_en),
    .o_debug_modules_en(o_debug_modules_en),
    .o_lockout_active(o_lockout_active));
